// ---- rtl/sfw_pkg.sv ----
/*
  Package for the special function register window decoder: addresses,
  reset values, access widths and the carrier structs of the core port.
  Assumes an 8-bit core with a 16-bit address and one clock.
*/
package sfw_pkg;

  // Window base and upper bound
  localparam logic [15:0] SFW_WIN_BASE = 16'hff00;
  localparam logic [15:0] SFW_WIN_TOP = 16'hffff;

  // Register addresses
  localparam logic [15:0] SFW_PORT_0_DATA = 16'hff00;
  localparam logic [15:0] SFW_PORT_2_DATA = 16'hff02;
  localparam logic [15:0] SFW_PORT_4_DATA = 16'hff04;
  localparam logic [15:0] SFW_PORT_5_DATA = 16'hff05;
  localparam logic [15:0] SFW_PORT_6_INPUT = 16'hff06;
  localparam logic [15:0] SFW_PORT_8_DATA = 16'hff08;
  localparam logic [15:0] SFW_PORT_9_DATA = 16'hff09;
  localparam logic [15:0] SFW_SERIAL_SHARED = 16'hff10;
  localparam logic [15:0] SFW_CONV_RESULT = 16'hff14;
  localparam logic [15:0] SFW_CONV_RESULT_BYTE = 16'hff15;
  localparam logic [15:0] SFW_TIMER_COMPARE = 16'hff16;
  localparam logic [15:0] SFW_TIMER_COUNT = 16'hff18;
  localparam logic [15:0] SFW_TIMER_CAPTURE = 16'hff1a;
  localparam logic [15:0] SFW_PORT_0_DIR = 16'hff20;
  localparam logic [15:0] SFW_PORT_2_DIR = 16'hff22;
  localparam logic [15:0] SFW_PORT_4_DIR = 16'hff24;
  localparam logic [15:0] SFW_PORT_5_DIR = 16'hff25;
  localparam logic [15:0] SFW_PORT_8_DIR = 16'hff28;
  localparam logic [15:0] SFW_PORT_9_DIR = 16'hff29;
  localparam logic [15:0] SFW_TIMER_CLK_SEL = 16'hff42;
  localparam logic [15:0] SFW_TIMER_MODE = 16'hff48;
  localparam logic [15:0] SFW_WATCH_MODE = 16'hff4a;
  localparam logic [15:0] SFW_COMPARATOR_MODE = 16'hff4e;

  // Reset values
  localparam logic [7:0] SFW_RST_PORT_DATA = 8'h00;
  localparam logic [7:0] SFW_RST_PORT_DIR = 8'hff;
  localparam logic [7:0] SFW_RST_TX_SHIFT = 8'hff;
  localparam logic [15:0] SFW_RST_COMPARE = 16'hffff;
  localparam logic [15:0] SFW_RST_COUNT = 16'h0000;
  localparam logic [7:0] SFW_RST_CTRL = 8'h00;
  // Value driven for undefined reads
  localparam logic [15:0] SFW_UNDEF_READ = 16'hffff;

  // Width of the bit number field inside the access struct
  localparam int SFW_BIT_W = 3;

  // Access widths
  typedef enum logic [1:0] {
    SFW_W_BIT = 2'b00,
    SFW_W_BYTE = 2'b01,
    SFW_W_WORD = 2'b10
  } sfw_width_e;

  // Addressing path used by the core
  typedef enum logic [1:0] {
    SFW_P_SHORT = 2'b00,
    SFW_P_DIRECT = 2'b01,
    SFW_P_OTHER = 2'b10
  } sfw_path_e;

  // One core request
  typedef struct packed {
    logic valid;
    logic write;
    sfw_width_e width;
    sfw_path_e path;
    logic [15:0] addr;
    logic [SFW_BIT_W-1:0] bitno;
    logic [15:0] wdata;
  } sfw_req_s;

  // One answer to the core
  typedef struct packed {
    logic valid;
    logic ok;
    logic [15:0] rdata;
  } sfw_rsp_s;

endpackage

// ---- rtl/sfw_decoder.sv ----
/*
  Special function register window: decodes the 256-byte window, checks
  width, direction and addressing path per register, and holds the
  register storage that stands in this block.
  Assumes requests are synchronous to clock; answers follow one cycle on.
*/
// Notes on behaviour
// RULE1: Decode registers only within FF00H to FFFFH.
// RULE2: Each register accepts only its permitted widths.
// RULE3: Core issues word accesses at even addresses.
// RULE4: Enforce read-only, write-only, read/write direction.
// RULE5: Port data resets 00H, direction FFH.
// RULE6: FF10H writes transmit, reads receive buffer.
// RULE7: Eight-bit converter result: byte read at FF15H.
// RULE8: Ten-bit converter result: word only at FF14H.
// RULE9: Word timer/converter access only by short direct.
// RULE10: Timer word registers also take direct byte access.
// RULE11: Timer compare at FF16H resets to FFFFH.
// RULE12: Count resets 0000H; capture undefined after reset.
// RULE13: Unmapped window addresses ignore writes, read undefined.
`timescale 1ns/10ps
`default_nettype none
module sfw_decoder
  import sfw_pkg::*;
#(
  parameter bit CONV_TEN_BIT = 1'b1 // Converter variant select
) (
  // Clock and reset
  input wire logic clock,
  input wire logic rst,
  // Core side
  input wire sfw_req_s req,
  output sfw_rsp_s rsp,
  // Peripheral inputs
  input wire logic [7:0] port_6_pins,
  input wire logic [7:0] rx_data,
  input wire logic rx_load,
  input wire logic [15:0] conv_data,
  input wire logic [15:0] count_value,
  input wire logic count_clear,
  input wire logic capture_strobe,
  // Peripheral outputs
  output logic [7:0] port_0_data,
  output logic [7:0] port_0_direction,
  output logic [7:0] serial_tx_shift,
  output logic tx_start,
  output logic [15:0] wide_timer_compare,
  output logic [7:0] wide_timer_mode
);

  // Small general register file for the plain byte registers
  localparam int NREG = 14;

  // Index of each plain byte register, or NREG when none
  function automatic int byte_index(input logic [15:0] a);
    unique case (a)
      SFW_PORT_0_DATA: byte_index = 0;
      SFW_PORT_2_DATA: byte_index = 1;
      SFW_PORT_4_DATA: byte_index = 2;
      SFW_PORT_5_DATA: byte_index = 3;
      SFW_PORT_8_DATA: byte_index = 4;
      SFW_PORT_9_DATA: byte_index = 5;
      SFW_PORT_0_DIR: byte_index = 6;
      SFW_PORT_2_DIR: byte_index = 7;
      SFW_PORT_4_DIR: byte_index = 8;
      SFW_PORT_5_DIR: byte_index = 9;
      SFW_PORT_8_DIR: byte_index = 10;
      SFW_PORT_9_DIR: byte_index = 11;
      SFW_TIMER_MODE: byte_index = 12;
      SFW_WATCH_MODE: byte_index = 13;
      default: byte_index = NREG;
    endcase
  endfunction

  // True when address is the low or high byte of a 16-bit pair
  function automatic logic in_pair(input logic [15:0] a, input logic [15:0] base);
    in_pair = (a[15:1] == base[15:1]);
  endfunction

  // Byte storage, comparator and clock select kept apart
  logic [7:0] regs_r [NREG];
  logic [7:0] clk_sel_r; // Byte only, no bit access
  logic [7:0] cmp_mode_r;
  logic [7:0] tx_r;
  logic tx_start_r;
  logic [7:0] rx_r;
  logic [15:0] compare_r;
  logic [15:0] count_r;
  logic [15:0] capture_r;
  sfw_rsp_s rsp_r;

  // Decode signals
  logic in_win;
  int idx;
  logic acc_ok;
  logic do_wr;
  logic [15:0] rd_val;
  logic [7:0] wr_byte;

  assign in_win = req.valid && (req.addr >= SFW_WIN_BASE) && (req.addr <= SFW_WIN_TOP); // RULE1
  assign idx = byte_index(req.addr);

  // New byte for bit or byte writes to byte register old
  function automatic logic [7:0] merge(input logic [7:0] old, input sfw_req_s r);
    logic [7:0] m;
    m = old;
    if (r.width == SFW_W_BIT) begin
      m[r.bitno] = r.wdata[0];
    end else begin
      m = r.wdata[7:0];
    end
    merge = m;
  endfunction

  // Access check: width, direction, path per register
  always_comb begin
    acc_ok = 1'b0;
    rd_val = SFW_UNDEF_READ; // RULE13
    if (in_win) begin
      if (idx != NREG) begin
        // Port data/direction and mode registers: bit or byte, read/write
        acc_ok = (req.width != SFW_W_WORD); // RULE2
        rd_val = {8'h00, regs_r[idx]};
      end else if (req.addr == SFW_PORT_6_INPUT) begin
        acc_ok = (req.width != SFW_W_WORD) && !req.write; // RULE4
        rd_val = {8'h00, port_6_pins};
      end else if (req.addr == SFW_TIMER_CLK_SEL) begin
        acc_ok = (req.width == SFW_W_BYTE); // RULE2
        rd_val = {8'h00, clk_sel_r};
      end else if (req.addr == SFW_COMPARATOR_MODE) begin
        acc_ok = (req.width != SFW_W_WORD);
        rd_val = {8'h00, cmp_mode_r};
      end else if (req.addr == SFW_SERIAL_SHARED) begin
        // Shared address: direction picks the register
        acc_ok = (req.width == SFW_W_BYTE); // RULE6
        rd_val = {8'h00, rx_r};
      end else if (!CONV_TEN_BIT && req.addr == SFW_CONV_RESULT_BYTE) begin
        acc_ok = (req.width == SFW_W_BYTE) && !req.write; // RULE7
        rd_val = {8'h00, conv_data[7:0]};
      end else if (CONV_TEN_BIT && req.addr == SFW_CONV_RESULT) begin
        acc_ok = (req.width == SFW_W_WORD) && !req.write && (req.path == SFW_P_SHORT); // RULE8 RULE9
        rd_val = conv_data;
      end else if (in_pair(req.addr, SFW_TIMER_COMPARE) || in_pair(req.addr, SFW_TIMER_COUNT)
                   || in_pair(req.addr, SFW_TIMER_CAPTURE)) begin
        // Timer pairs: word by short direct, byte by direct
        if (req.width == SFW_W_WORD) begin
          acc_ok = !req.addr[0] && (req.path == SFW_P_SHORT); // RULE3 RULE9
        end else begin
          acc_ok = (req.width == SFW_W_BYTE) && (req.path != SFW_P_OTHER); // RULE10
        end
        if (in_pair(req.addr, SFW_TIMER_COMPARE)) begin
          acc_ok = acc_ok && req.write; // RULE4
        end else begin
          acc_ok = acc_ok && !req.write; // RULE4
          rd_val = in_pair(req.addr, SFW_TIMER_COUNT) ? count_r : capture_r;
          if (req.width == SFW_W_BYTE) begin
            rd_val = {8'h00, req.addr[0] ? rd_val[15:8] : rd_val[7:0]};
          end
        end
      end
    end
    if (!acc_ok) begin
      rd_val = SFW_UNDEF_READ; // RULE13
    end
  end

  assign do_wr = acc_ok && req.write;
  assign wr_byte = (idx != NREG) ? merge(regs_r[idx], req) : req.wdata[7:0];

  // Plain byte registers, ports reset by kind
  always_ff @(posedge clock or posedge rst) begin
    if (rst) begin
      for (int i = 0; i < NREG; i++) begin
        if (i >= 6 && i <= 11) begin
          regs_r[i] <= SFW_RST_PORT_DIR; // RULE5
        end else begin
          regs_r[i] <= SFW_RST_PORT_DATA; // RULE5
        end
      end
    end else if (do_wr && idx != NREG) begin
      regs_r[idx] <= wr_byte;
    end
  end

  // Clock select and comparator mode
  always_ff @(posedge clock or posedge rst) begin
    if (rst) begin
      clk_sel_r <= SFW_RST_CTRL;
      cmp_mode_r <= SFW_RST_CTRL;
    end else if (do_wr && req.addr == SFW_TIMER_CLK_SEL) begin
      clk_sel_r <= req.wdata[7:0];
    end else if (do_wr && req.addr == SFW_COMPARATOR_MODE) begin
      cmp_mode_r <= merge(cmp_mode_r, req);
    end
  end

  // Serial transmit load and receive capture
  always_ff @(posedge clock or posedge rst) begin
    if (rst) begin
      tx_r <= SFW_RST_TX_SHIFT; // RULE6
      tx_start_r <= 1'b0;
      rx_r <= 8'h00; // Content left undefined; zero keeps sims clean
    end else begin
      tx_start_r <= do_wr && req.addr == SFW_SERIAL_SHARED; // RULE6
      if (do_wr && req.addr == SFW_SERIAL_SHARED) begin
        tx_r <= req.wdata[7:0];
      end
      if (rx_load) begin
        rx_r <= rx_data;
      end
    end
  end

  // Timer compare: word or direct byte writes
  always_ff @(posedge clock or posedge rst) begin
    if (rst) begin
      compare_r <= SFW_RST_COMPARE; // RULE11
    end else if (do_wr && in_pair(req.addr, SFW_TIMER_COMPARE)) begin
      if (req.width == SFW_W_WORD) begin
        compare_r <= req.wdata;
      end else if (req.addr[0]) begin
        compare_r[15:8] <= req.wdata[7:0]; // RULE10
      end else begin
        compare_r[7:0] <= req.wdata[7:0]; // RULE10
      end
    end
  end

  // Count mirror and capture; clear takes priority over load
  always_ff @(posedge clock or posedge rst) begin
    if (rst) begin
      count_r <= SFW_RST_COUNT; // RULE12
      capture_r <= 16'h0000; // Content left undefined; zero keeps sims clean
    end else begin
      count_r <= count_clear ? SFW_RST_COUNT : count_value;
      if (capture_strobe) begin
        capture_r <= count_value;
      end
    end
  end

  // Answer register, one cycle after the request
  always_ff @(posedge clock or posedge rst) begin
    if (rst) begin
      rsp_r <= '0;
    end else begin
      rsp_r.valid <= req.valid;
      rsp_r.ok <= acc_ok;
      rsp_r.rdata <= req.write ? SFW_UNDEF_READ : rd_val; // RULE4
    end
  end

  assign rsp = rsp_r;
  assign port_0_data = regs_r[0];
  assign port_0_direction = regs_r[6];
  assign serial_tx_shift = tx_r;
  assign tx_start = tx_start_r;
  assign wide_timer_compare = compare_r;
  assign wide_timer_mode = regs_r[12];

endmodule // sfw_decoder
`default_nettype wire

// ---- dv/sfw_decoder_checker.sv ----
/*
  Checker for the register window decoder: answer timing and refusals.
  Assumes it is bound into sfw_decoder and sees only its ports.
*/
`timescale 1ns/10ps
`default_nettype none
module sfw_decoder_checker
  import sfw_pkg::*;
#(
  parameter bit CONV_TEN_BIT = 1'b1 // Converter variant
) (
  // Clock and reset
  input wire logic clock,
  input wire logic rst,
  // Core side
  input wire sfw_req_s req,
  input wire sfw_rsp_s rsp,
  // Register outputs
  input wire logic [7:0] port_0_data,
  input wire logic [7:0] port_0_direction,
  input wire logic [7:0] serial_tx_shift,
  input wire logic tx_start,
  input wire logic [15:0] wide_timer_compare
);
  // One domain only
  default clocking cb @(posedge clock); endclocking
  default disable iff (rst);

  property p_win; req.valid && req.addr[15:8] != 8'hff |=> rsp.valid && !rsp.ok; endproperty
  a_win: assert property (p_win) else $error("access outside window accepted");
  property p_wid; req.valid && req.width == SFW_W_BIT && req.addr == SFW_TIMER_CLK_SEL
    |=> rsp.valid && !rsp.ok; endproperty
  a_wid: assert property (p_wid) else $error("bit access accepted on byte register");
  property p_odd; req.valid && req.width == SFW_W_WORD && req.addr[0] |=> !rsp.ok; endproperty
  a_odd: assert property (p_odd) else $error("odd word access accepted");
  property p_ro; req.valid && req.write && req.addr == SFW_PORT_6_INPUT |=> !rsp.ok; endproperty
  a_ro: assert property (p_ro) else $error("write to input port accepted");
  property p_prst; $fell(rst) |-> port_0_data == SFW_RST_PORT_DATA
    && port_0_direction == SFW_RST_PORT_DIR; endproperty
  a_prst: assert property (p_prst) else $error("port reset value wrong");
  property p_tx; req.valid && req.write && req.width == SFW_W_BYTE && req.path == SFW_P_DIRECT
    && req.addr == SFW_SERIAL_SHARED
    |=> tx_start && {8'h00, serial_tx_shift} == ($past(req.wdata) & 16'h00ff); endproperty
  a_tx: assert property (p_tx) else $error("transmit load missing");
  property p_conv; CONV_TEN_BIT && req.valid && req.width != SFW_W_WORD
    && (req.addr == SFW_CONV_RESULT || req.addr == SFW_CONV_RESULT_BYTE) |=> !rsp.ok; endproperty
  a_conv: assert property (p_conv) else $error("byte converter access accepted");
  property p_path; req.valid && req.width == SFW_W_WORD && req.path != SFW_P_SHORT
    && req.addr == SFW_TIMER_COMPARE |=> !rsp.ok; endproperty
  a_path: assert property (p_path) else $error("word access off short path accepted");
  property p_cmp; $fell(rst) |-> wide_timer_compare == SFW_RST_COMPARE; endproperty
  a_cmp: assert property (p_cmp) else $error("compare reset value wrong");
  property p_und; rsp.valid && !rsp.ok |-> rsp.rdata == SFW_UNDEF_READ; endproperty
  a_und: assert property (p_und) else $error("refused access read data wrong");
endmodule // sfw_decoder_checker

bind sfw_decoder sfw_decoder_checker #(.CONV_TEN_BIT(CONV_TEN_BIT)) u_sfw_decoder_checker (
  .clock(clock), .rst(rst), .req(req), .rsp(rsp), .port_0_data(port_0_data),
  .port_0_direction(port_0_direction), .serial_tx_shift(serial_tx_shift),
  .tx_start(tx_start), .wide_timer_compare(wide_timer_compare));
`default_nettype wire

// ---- dv/sfw_core_model.sv ----
/*
  Core model: puts one request per clock on the decoder's request port.
  Assumes the decoder takes a request at each rising edge with valid high.
*/
`timescale 1ns/10ps
`default_nettype none
module sfw_core_model
  import sfw_pkg::*;
(
  // Clock
  input wire logic clock,
  // Request to the decoder
  output sfw_req_s req
);
  // Quiet until the first request
  initial req = '0;

  // Changed just after the edge, held for one whole cycle
  task automatic drive(input sfw_req_s r, input bit odd_ok);
    @(posedge clock);
    #1;
    // Even word address unless a fault is asked for
    if (r.width == SFW_W_WORD && !odd_ok) r.addr[0] = 1'b0;
    // Idle fields flip, so stale values are never trusted
    if (!r.valid) r = {1'b0, ~req[$bits(sfw_req_s)-2:0]};
    req = r;
  endtask
endmodule // sfw_core_model
`default_nettype wire

// ---- dv/tb_sfw_decoder.sv ----
/*
  Testbench for the register window decoder: core model drives, a monitor
  compares each answer with the oldest expected note. Ten-bit converter, eight-bit variant alongside.
*/
`timescale 1ns/10ps
`default_nettype none
`define CHK(g, e) begin n_checks++; if ((g) !== (e)) begin err_total++; \
  $display("mismatch t=%0t got=%h exp=%h", $time, g, e); end end
module tb_sfw_decoder
  import sfw_pkg::*;
;
  logic clock = 0, rst = 1, rx_load = 0, count_clear = 1, cap = 0;
  logic [7:0] pins, rxd, v;
  logic [15:0] conv, cnt, d;
  logic [32:0] q[$]; // Expected {ok, mask, data}
  sfw_req_s req;
  sfw_rsp_s rsp, rsp8; // rsp8 from the eight-bit converter variant
  logic [7:0] p0d, p0m, txs, tmode;
  logic [15:0] cmp;
  int err_total = 0, n_checks = 0, seed = 12;
  localparam sfw_width_e wt = SFW_W_BIT, wb = SFW_W_BYTE, ww = SFW_W_WORD;
  localparam sfw_path_e ps = SFW_P_SHORT, pd = SFW_P_DIRECT;

  sfw_core_model u_sfw_core_model (.clock(clock), .req(req));
  sfw_decoder u_sfw_decoder (.clock(clock), .rst(rst), .req(req), .rsp(rsp),
    .port_6_pins(pins), .rx_data(rxd), .rx_load(rx_load), .conv_data(conv),
    .count_value(cnt), .count_clear(count_clear), .capture_strobe(cap),
    .port_0_data(p0d), .port_0_direction(p0m), .serial_tx_shift(txs), .tx_start(),
    .wide_timer_compare(cmp), .wide_timer_mode(tmode));
  // Eight-bit converter variant shares the same request stream
  sfw_decoder #(.CONV_TEN_BIT(1'b0)) u_sfw_decoder_8 (.clock(clock), .rst(rst), .req(req),
    .rsp(rsp8), .port_6_pins(pins), .rx_data(rxd), .rx_load(rx_load), .conv_data(conv),
    .count_value(cnt), .count_clear(count_clear), .capture_strobe(cap),
    .port_0_data(), .port_0_direction(), .serial_tx_shift(), .tx_start(),
    .wide_timer_compare(), .wide_timer_mode());

  initial forever #5 clock = ~clock;

  // Bit number rides in d[10:8], bit value in d[0]
  task automatic op(bit wr, sfw_width_e w, sfw_path_e p, logic [15:0] a, d,
                    bit ok, logic [15:0] rd, bit f = 0);
    logic [15:0] m;
    m = (w == SFW_W_WORD) ? 16'hffff : 16'h00ff;
    q.push_back({ok, m, ((ok && !wr) ? rd : 16'hffff) & m});
    u_sfw_core_model.drive('{1'b1, wr, w, p, a, d[10:8], d}, f);
  endtask

  task automatic conclude();
    if (err_total == 0 && n_checks > 0) $display("Result: passed");
    else $display("Result: failed");
    $finish;
  endtask

  // Answer monitor, clear of the edge's updates
  always @(posedge clock) begin
    #2;
    if (rsp.valid === 1'b1) begin
      logic [32:0] e;
      e = q.pop_front();
      `CHK({rsp.ok, rsp.rdata & e[31:16]}, {e[32], e[15:0]})
    end
  end

  initial begin
    {pins, rxd, conv, cnt, d} = {$random(seed), $random(seed)};
    repeat (12) @(posedge clock);
    #1 rst = 0;
    `CHK({p0m, txs, cmp}, 32'hffffffff)
    rx_load = 1;
    @(posedge clock) #1 rx_load = 0;
    op(0, wb, pd, 16'hff00, d, 1, 16'h0000);
    op(0, wb, pd, 16'hff20, d, 1, 16'h00ff);
    op(0, ww, ps, 16'hff14, d, 1, conv);
    op(0, wb, pd, 16'hff14, d, 0, 0);
    `CHK(rsp8.ok, 1'b0)
    op(0, wb, pd, 16'hff15, d, 0, 0);
    op(0, wb, pd, 16'hff10, d, 1, {8'h00, rxd});
    `CHK({rsp8.ok, rsp8.rdata}, {1'b1, 8'h00, conv[7:0]})
    op(1, wb, pd, 16'hff10, d, 1, 0);
    op(0, ww, ps, 16'hff16, d, 0, 0);
    op(1, ww, pd, 16'hff16, d, 0, 0);
    op(1, ww, ps, 16'hff16, d, 1, 0);
    op(1, wb, pd, 16'hff17, 16'h005a, 1, 0);
    op(0, ww, ps, 16'hff19, d, 0, 0, 1);
    op(0, ww, ps, 16'hff18, d, 1, 16'h0000);
    op(1, wb, pd, 16'hff06, d, 0, 0);
    op(0, wb, pd, 16'hff06, d, 1, {8'h00, pins});
    op(0, wt, pd, 16'hff42, d, 0, 0);
    op(0, ww, ps, 16'hff00, d, 0, 0);
    op(1, wt, pd, 16'hff00, 16'h0301, 1, 0);
    op(1, wb, pd, 16'hff01, d, 0, 0);
    op(0, wb, pd, 16'hff01, d, 0, 0);
    op(0, wb, pd, 16'hfe00, d, 0, 0);
    op(1, wb, pd, 16'hff48, 16'h00a5, 1, 0);
    u_sfw_core_model.drive('0, 0);
    `CHK(tmode, 8'ha5)
    // Release the count clear and capture the live count once
    count_clear = 0;
    cap = 1;
    u_sfw_core_model.drive('0, 0);
    cap = 0;
    op(0, ww, ps, 16'hff18, d, 1, cnt);
    op(0, wb, pd, 16'hff19, d, 1, {8'h00, cnt[15:8]});
    op(0, ww, ps, 16'hff1a, d, 1, cnt);
    u_sfw_core_model.drive('0, 0);
    `CHK(p0d, 8'h08)
    `CHK(txs, d[7:0])
    `CHK(cmp, {8'h5a, d[7:0]})
    // Random direction values, written then read back
    repeat (8) begin
      v = $random(seed);
      op(1, wb, pd, 16'hff20, {8'h00, v}, 1, 0);
      u_sfw_core_model.drive('0, 0);
      `CHK(p0m, v)
      op(0, wb, pd, 16'hff20, d, 1, {8'h00, v});
    end
    repeat (3) u_sfw_core_model.drive('0, 0);
    `CHK(q.size(), 0)
    conclude();
  end

  // Hang guard, far beyond the sequence length
  initial begin
    #20000;
    err_total++;
    conclude();
  end
endmodule // tb_sfw_decoder
`default_nettype wire
